/* File: sim/sewp_host.sv */
// Purpose: two-wire bus controller model for the eeprom link
// Assumes: sda has a pull-up outside; one bit lasts eight sys_clk
// Notes:   scl idles high and stands still between frames
`timescale 1ns/100ps

module sewp_host (
   input  wire logic sys_clk,  // system clock
   input  wire logic sda,      // resolved sda level
   output logic      scl,      // serial clock to device
   output logic      sda_low   // high while pulling sda low
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // step just after the edge so pins never race the sampler
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // data set in low phase, sampled late in high phase
   task automatic bit_io(input logic b, output logic r);
      tick(1);
      sda_low = ~b;
      tick(3);
      scl     = 1'b1;
      tick(3);
      r       = sda;
      tick(1);
      scl     = 1'b0;
   endtask

   // long low phase first: device may still hold its ack
   task automatic start();
      sda_low = 1'b0;
      tick(4);
      scl     = 1'b1;
      tick(2);
      sda_low = 1'b1;
      tick(2);
      scl     = 1'b0;
   endtask

   task automatic stop();
      sda_low = 1'b1;
      tick(2);
      scl     = 1'b1;
      tick(2);
      sda_low = 1'b0;
      tick(2);
   endtask

   // byte msb first, ninth clock released to read the ack
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic get(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
   endtask
endmodule

/* File: sim/tb_serial_eeprom_write_protect.sv */
// Purpose: self-checking bench of the write-protected serial eeprom
// Assumes: short write cycle parameter; straps and protect pin driven
// Notes:   protect flag survives reset, so its test runs last
`timescale 1ns/100ps

module tb_serial_eeprom_write_protect;
   import sewp_pkg::*;
   localparam int WRC = 200;
   logic       sys_clk, rst_n, wp, scl, host_low, sda_oe, sda_out, k;
   logic [2:0] strap;
   logic [7:0] d;
   int         err_count, samples_checked, cycles;
   wire logic  sda = ~(sda_oe | host_low);  // pull-up on the wire

   sewp_top #(.WR_CYCLES(WRC)) uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .select_strap_bit2(strap[2]),
      .select_strap_bit1(strap[1]), .select_strap_bit0(strap[0]),
      .write_protect_pin(wp));
   sewp_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl),
      .sda_low(host_low));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // hang guard, well above the expected run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   function automatic logic [7:0] dw(input logic [3:0] c, input logic rw);
      return {c, strap, rw};
   endfunction

   task automatic pa(input logic [7:0] v, input logic e);
      host.put(v, k);
      chk("ack", {7'h00, e}, {7'h00, k});
   endtask

   // full wait after every write, protected or not
   task automatic wr(input logic [3:0] c, input logic [7:0] a, input int n,
                     input logic [7:0] d0);
      host.start();
      pa(dw(c, 1'b0), 1'b1);
      pa(a, 1'b1);
      for (int i = 0; i < n; i++) pa(d0 + 8'(i), 1'b1);
      host.stop();
      host.tick(WRC + 10);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.start();
      pa(dw(CODE_ARRAY, 1'b0), 1'b1);
      pa(a, 1'b1);
      host.start();
      pa(dw(CODE_ARRAY, 1'b1), 1'b1);
      host.get(1'b1, d);
      host.stop();
      chk("read data", e, d);
   endtask

   task automatic t_plain();
      wr(CODE_ARRAY, 8'h10, 1, 8'h5a);
      rd(8'h10, 8'h5a);
      chk("sda drive", 8'h00, {7'h00, sda_out});
   endtask

   task automatic t_select();
      host.start();
      pa({CODE_ARRAY, 3'b010, 1'b0}, 1'b0);
      host.stop();
      host.start();
      pa(dw(4'hb, 1'b0), 1'b0);
      host.stop();
   endtask

   // a full page from 0x2e: the pointer wraps to 0x20 after 0x2f
   task automatic t_page();
      wr(CODE_ARRAY, 8'h2e, 16, 8'h40);
      rd(8'h2e, 8'h40);
      // current read of two bytes, controller acks the first
      host.start();
      pa(dw(CODE_ARRAY, 1'b1), 1'b1);
      host.get(1'b0, d);
      chk("next read", 8'h41, d);
      host.get(1'b1, d);
      chk("next read", ERASED, d);
      host.stop();
      rd(8'h20, 8'h42);
      rd(8'h30, ERASED);
   endtask

   task automatic t_wp();
      wp = 1'b1;
      wr(CODE_ARRAY, 8'h90, 1, 8'h77);
      wp = 1'b0;
      rd(8'h90, ERASED);
   endtask

   task automatic t_busy();
      host.start();
      pa(dw(CODE_ARRAY, 1'b0), 1'b1);
      pa(8'h60, 1'b1);
      pa(8'h11, 1'b1);
      host.stop();
      host.start();
      pa(dw(CODE_ARRAY, 1'b0), 1'b0);
      host.stop();
      host.tick(WRC + 10);
      rd(8'h60, 8'h11);
   endtask

   task automatic probe(input logic e);
      host.start();
      pa(dw(CODE_PROTECT, 1'b0), e);
      host.stop();
   endtask

   task automatic t_protect();
      probe(1'b1);
      wr(CODE_PROTECT, 8'h00, 1, 8'h00);
      probe(1'b0);
      wr(CODE_ARRAY, 8'h10, 1, 8'h99);
      rd(8'h10, 8'h5a);
      wr(CODE_ARRAY, 8'h85, 1, 8'h3c);
      rd(8'h85, 8'h3c);
      rst_n = 1'b0;
      host.tick(5);
      rst_n = 1'b1;
      host.tick(4);
      probe(1'b0);
   endtask

   initial begin
      rst_n = 1'b0;
      wp    = 1'b0;  // driven low in place of the pull-down
      strap = 3'b101;
      host.tick(5);
      rst_n = 1'b1;
      host.tick(4);
      t_plain();
      t_select();
      t_page();
      t_wp();
      t_busy();
      t_protect();
      test_done();
   end
endmodule

/* File: verilog/sewp_mem.sv */
// Purpose: 256 x 8 storage array of the eeprom
// Assumes: one write port and one registered read port
// Notes:   no reset; contents stand for nonvolatile cells
`timescale 1ns/100ps

module sewp_mem (
   input wire logic sys_clk,   // system clock
   sewp_mem_if.mem  mem_port   // write and read traffic
);
   import sewp_pkg::*;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // cells never see rst_n, so data outlive a reset (see RL1)
   logic [DATA_W-1:0] store [DEPTH];

   // a fresh part reads as erased
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         store[i] = ERASED;
      end
   end

   // write port
   always_ff @(posedge sys_clk) begin
      if (mem_port.wr_en) begin
         store[mem_port.wr_addr] <= mem_port.wr_data;   // see RL1
      end
   end

   // read port, always enabled, registered output
   always_ff @(posedge sys_clk) begin
      mem_port.rd_data <= store[mem_port.rd_addr];
   end

endmodule

/* File: verilog/sewp_mem_if.sv */
// Purpose: carries array write and read traffic to the storage module
// Assumes: both ends on sys_clk
// Notes:   read data are registered, one cycle after the address
`timescale 1ns/100ps

interface sewp_mem_if;
   import sewp_pkg::*;
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;

   modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

/* File: verilog/sewp_pkg.sv */
// Purpose: shared constants and types of the write-protected serial eeprom
// Assumes: one system clock of 125 MHz samples the whole two-wire link
// Notes:   timing counts derive from the clock rate held here

package sewp_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ        = 125_000_000;
   localparam int T_WR_US       = 5000;         // write cycle, microseconds
   // longest time, so rounding down is the safe side
   localparam int WR_CYCLES_DEF = T_WR_US * (CLK_HZ / 1_000_000);
   localparam int PROG_CNT_W    = 20;

   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;
   localparam int DEPTH   = 256;
   localparam int SEL_W   = 3;
   localparam int PAGE_W  = 4;
   localparam logic [DATA_W-1:0] ERASED = 8'hff;

   // ---------------------------------------------------------------
   // address word layout and control codes
   // ---------------------------------------------------------------
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 4;
   localparam int SEL_MSB  = 3;
   localparam int SEL_LSB  = 1;
   localparam int RW_BIT   = 0;
   localparam int HALF_BIT = 7;                 // address bit of upper half
   localparam logic [3:0] CODE_ARRAY   = 4'ha;  // array access
   localparam logic [3:0] CODE_PROTECT = 4'h6;  // protect register
   localparam logic [3:0] LAST_BIT     = 4'h8;  // bits per byte
   localparam int BIT_CNT_W = 4;

   // ---------------------------------------------------------------
   // link sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DEV   = 3'b001,
      ST_WADDR = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_PROG  = 3'b101
   } sewp_state_type;

endpackage

/* File: verilog/sewp_sync.sv */
// Purpose: two-stage synchroniser for the link pins and straps
// Assumes: inputs are asynchronous to sys_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps

module sewp_sync #(
   parameter int WIDTH = 1                   // number of lines
) (
   input  wire logic             sys_clk,    // system clock
   input  wire logic             rst_n,      // sync reset, active low
   input  wire logic [WIDTH-1:0] async_in,   // raw pin levels
   output logic      [WIDTH-1:0] sync_out    // synchronised levels
);

   // ---------------------------------------------------------------
   // two flip-flops per line
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] stage1_reg;

   // resets to low, the same level the pin pull-downs give
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         sync_out   <= '0;
      end else begin
         stage1_reg <= async_in;
         sync_out   <= stage1_reg;
      end
   end

endmodule

/* File: verilog/sewp_top.sv */
// Purpose: two-wire serial eeprom, 256 x 8, with write protection
// Assumes: scl and sda sampled by sys_clk, far faster than the link
// Notes:   data bytes go to the array as each byte completes; the
//          programming time after stop is then spent as a busy window
`timescale 1ns/100ps

// How it works
// (RL1) array holds 256 bytes, 8-bit addressed
// (RL2) software protect, once set, never clears
// (RL3) soft protect blocks lower half only
// (RL4) protect pin high blocks all writes
// (RL5) no protection: every location writable
// (RL6) floating protect pin reads as low
// (RL7) sample on scl rise, drive on fall
// (RL8) sda only pulled low or released
// (RL9) three straps give the bus identity
// (RL10) respond only when select bits match straps
// (RL11) floating straps read as low
// (RL12) page write up to sixteen bytes
// (RL13) self-timed programming within 5 ms
// (RL14) protect status readable by acknowledge probe
// (RL15) codes 1010 array, 0110 protect register
// (RL16) no acknowledge for 0110 once protected
// (RL17) protected writes acknowledged, memory untouched
// (RL18) bus ignored during write cycle
// (RL19) protect state kept as nonvolatile
// (RL20) page write wraps low four bits
module sewp_top
   import sewp_pkg::*;
#(
   parameter int WR_CYCLES = sewp_pkg::WR_CYCLES_DEF  // write cycle clocks
) (
   input  wire logic sys_clk,            // system clock, 125 MHz
   input  wire logic rst_n,              // sync reset, active low
   input  wire logic scl_pin,            // serial clock from controller
   input  wire logic sda_in,             // serial data line level
   output logic      sda_out,            // serial data drive value
   output logic      sda_oe,             // high while pulling sda low
   input  wire logic select_strap_bit2,  // bus identity strap, msb
   input  wire logic select_strap_bit1,  // bus identity strap
   input  wire logic select_strap_bit0,  // bus identity strap, lsb
   input  wire logic write_protect_pin   // high inhibits all writes
);
   import sewp_pkg::*;

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   // next address inside the same page
   function automatic logic [ADDR_W-1:0] page_next(
      input logic [ADDR_W-1:0] a);
      page_next = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 4'h1};
   endfunction

   // array write permission from both protections
   function automatic logic write_ok(input logic [ADDR_W-1:0] a,
                                     input logic wp,
                                     input logic swp);
      write_ok = !wp && !(swp && !a[HALF_BIT]); // see RL3, RL4, RL5
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisation and edge detection
   // ---------------------------------------------------------------
   logic [5:0]         pins_s;
   logic               scl_s;
   logic               sda_s;
   logic               wp_s;
   logic [SEL_W-1:0]   strap_s;
   logic               scl_d_reg;
   logic               sda_d_reg;
   logic               scl_rise;
   logic               scl_fall;
   logic               start_evt;
   logic               stop_evt;

   sewp_sync #(
      .WIDTH (6)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in ({write_protect_pin, select_strap_bit2, select_strap_bit1,
                  select_strap_bit0, sda_in, scl_pin}),
      .sync_out (pins_s)
   );

   // floating strap and protect pins arrive low through the pad pull-downs
   assign scl_s   = pins_s[0];
   assign sda_s   = pins_s[1];
   assign strap_s = pins_s[4:2];   // see RL9, RL11
   assign wp_s    = pins_s[5];     // see RL6

   // delayed copies for edge finding
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         scl_d_reg <= 1'b0;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // start and stop are sda moves while scl stays high
   assign scl_rise  = scl_s && !scl_d_reg;   // see RL7
   assign scl_fall  = !scl_s && scl_d_reg;   // see RL7
   assign start_evt = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   assign stop_evt  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   sewp_state_type         state_reg;
   sewp_state_type         nxt_state_reg;
   sewp_state_type         nxt_state_next;
   logic [BIT_CNT_W-1:0]   bit_cnt_reg;
   logic                   ack_phase_reg;
   logic [DATA_W-1:0]      shift_reg;
   logic [ADDR_W-1:0]      addr_reg;
   logic                   protect_mode_reg;
   logic                   data_seen_reg;
   logic                   master_nack_reg;
   logic                   sda_oe_reg;
   logic                   ack_next;
   logic                   byte_evt;
   logic                   rd_byte_evt;
   logic                   wr_commit;
   logic                   prog_done;
   logic [PROG_CNT_W-1:0]  prog_cnt_reg;
   logic                   swp_reg = 1'b0;   // unprogrammed part, see RL19
   sewp_mem_if             mem_bus ();

   // a received byte is complete at the fall after its eighth bit
   assign byte_evt    = scl_fall && !ack_phase_reg &&
                        bit_cnt_reg == LAST_BIT &&
                        (state_reg == ST_DEV || state_reg == ST_WADDR ||
                         state_reg == ST_WDATA);
   assign rd_byte_evt = scl_fall && !ack_phase_reg &&
                        bit_cnt_reg == LAST_BIT && state_reg == ST_RDATA;
   assign wr_commit   = stop_evt && state_reg == ST_WDATA && data_seen_reg;
   assign prog_done   = state_reg == ST_PROG && prog_cnt_reg == '0;

   // ---------------------------------------------------------------
   // byte decision: acknowledge and following state
   // ---------------------------------------------------------------
   always_comb begin
      ack_next       = 1'b0;
      nxt_state_next = ST_IDLE;
      unique case (state_reg)
         ST_DEV: begin
            // identity must match the straps (see RL10)
            if (shift_reg[SEL_MSB:SEL_LSB] == strap_s) begin
               if (shift_reg[CODE_MSB:CODE_LSB] == CODE_ARRAY) begin
                  ack_next       = 1'b1;                        // see RL15
                  nxt_state_next = shift_reg[RW_BIT] ? ST_RDATA : ST_WADDR;
               end else if (shift_reg[CODE_MSB:CODE_LSB] == CODE_PROTECT
                            && !swp_reg) begin
                  // probe answer shows protect status (see RL14, RL16)
                  ack_next       = 1'b1;
                  nxt_state_next = shift_reg[RW_BIT] ? ST_IDLE : ST_WADDR;
               end
            end
         end
         ST_WADDR: begin
            ack_next       = 1'b1;
            nxt_state_next = ST_WDATA;
         end
         ST_WDATA: begin
            // acknowledged even when protected (see RL17)
            ack_next       = 1'b1;
            nxt_state_next = ST_WDATA;
         end
         ST_IDLE, ST_RDATA, ST_PROG: begin
            ack_next       = 1'b0;
            nxt_state_next = ST_IDLE;
         end
         default: begin
            ack_next       = 1'b0;
            nxt_state_next = ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // link sequencer
   // ---------------------------------------------------------------
   // the busy window comes first so nothing on the bus reaches it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg        <= ST_IDLE;
         nxt_state_reg    <= ST_IDLE;
         bit_cnt_reg      <= '0;
         ack_phase_reg    <= 1'b0;
         shift_reg        <= '0;
         sda_oe_reg       <= 1'b0;
         protect_mode_reg <= 1'b0;
         data_seen_reg    <= 1'b0;
         master_nack_reg  <= 1'b0;
      end else if (state_reg == ST_PROG) begin
         sda_oe_reg <= 1'b0;                         // see RL18
         if (prog_done) begin
            state_reg <= ST_IDLE;                    // see RL13
         end
      end else if (start_evt) begin
         state_reg     <= ST_DEV;
         bit_cnt_reg   <= '0;
         ack_phase_reg <= 1'b0;
         sda_oe_reg    <= 1'b0;
         data_seen_reg <= 1'b0;
      end else if (stop_evt) begin
         state_reg     <= wr_commit ? ST_PROG : ST_IDLE;
         ack_phase_reg <= 1'b0;
         sda_oe_reg    <= 1'b0;
      end else if (state_reg != ST_IDLE && scl_rise) begin
         // incoming data taken on the rising edge (see RL7)
         if (!ack_phase_reg && bit_cnt_reg != LAST_BIT) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (state_reg != ST_RDATA) begin
               shift_reg <= {shift_reg[DATA_W-2:0], sda_s};
            end
         end else if (ack_phase_reg && state_reg == ST_RDATA) begin
            master_nack_reg <= sda_s;
         end
      end else if (state_reg != ST_IDLE && scl_fall) begin
         if (byte_evt) begin
            ack_phase_reg <= 1'b1;
            sda_oe_reg    <= ack_next;
            nxt_state_reg <= nxt_state_next;
            if (state_reg == ST_DEV) begin
               protect_mode_reg <=
                  shift_reg[CODE_MSB:CODE_LSB] == CODE_PROTECT;
            end
            if (state_reg == ST_WDATA) begin
               data_seen_reg <= 1'b1;
            end
         end else if (rd_byte_evt) begin
            // let go so the controller can acknowledge
            ack_phase_reg <= 1'b1;
            sda_oe_reg    <= 1'b0;
            nxt_state_reg <= ST_RDATA;
         end else if (ack_phase_reg) begin
            ack_phase_reg <= 1'b0;
            bit_cnt_reg   <= '0;
            if (nxt_state_reg == ST_RDATA &&
                !(state_reg == ST_RDATA && master_nack_reg)) begin
               state_reg  <= ST_RDATA;
               shift_reg  <= mem_bus.rd_data;
               sda_oe_reg <= !mem_bus.rd_data[DATA_W-1];
            end else begin
               state_reg  <= (state_reg == ST_RDATA) ? ST_IDLE
                                                      : nxt_state_reg;
               sda_oe_reg <= 1'b0;
            end
         end else if (state_reg == ST_RDATA) begin
            // next outgoing bit changes on the falling edge
            shift_reg  <= {shift_reg[DATA_W-2:0], 1'b0};
            sda_oe_reg <= !shift_reg[DATA_W-2];
         end
      end
   end

   // ---------------------------------------------------------------
   // address pointer
   // ---------------------------------------------------------------
   // reads roll over the whole array, writes stay inside the page
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         addr_reg <= '0;
      end else if (byte_evt && state_reg == ST_WADDR) begin
         addr_reg <= shift_reg;                        // see RL1
      end else if (byte_evt && state_reg == ST_WDATA) begin
         addr_reg <= page_next(addr_reg);              // see RL12, RL20
      end else if (rd_byte_evt) begin
         addr_reg <= addr_reg + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // array write port
   // ---------------------------------------------------------------
   // blocked bytes still advance the pointer, memory stays as it was
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_bus.wr_en   <= 1'b0;
         mem_bus.wr_addr <= '0;
         mem_bus.wr_data <= '0;
      end else begin
         mem_bus.wr_en   <= byte_evt && state_reg == ST_WDATA &&
                            !protect_mode_reg &&
                            write_ok(addr_reg, wp_s, swp_reg); // see RL3-5
         mem_bus.wr_addr <= addr_reg;
         mem_bus.wr_data <= shift_reg;
      end
   end

   assign mem_bus.rd_addr = addr_reg;

   sewp_mem u_mem (
      .sys_clk  (sys_clk),
      .mem_port (mem_bus)
   );

   // ---------------------------------------------------------------
   // software protect flag and write cycle timer
   // ---------------------------------------------------------------
   // no reset on purpose: the flag stands for a fused cell
   always_ff @(posedge sys_clk) begin
      if (wr_commit && protect_mode_reg && !wp_s) begin
         swp_reg <= 1'b1;                              // see RL2, RL19
      end
   end

   // self-timed cycle; also spent when every byte was refused
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prog_cnt_reg <= '0;
      end else if (wr_commit) begin
         prog_cnt_reg <= PROG_CNT_W'(WR_CYCLES - 1);   // see RL13
      end else if (prog_cnt_reg != '0) begin
         prog_cnt_reg <= prog_cnt_reg - 20'h0_0001;
      end
   end

   // open drain: the only value ever driven is low
   assign sda_out = 1'b0;                              // see RL8
   assign sda_oe  = sda_oe_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_dev_byte;
      byte_evt && state_reg == ST_DEV;
   endsequence

   sequence s_commit;
      wr_commit;
   endsequence

   AST_SWP_STICKY: assert property ($past(swp_reg) |-> swp_reg) // RL2
      else $error("software protect flag cleared");
   AST_HW_WP: assert property (mem_bus.wr_en |-> !$past(wp_s)) // RL4
      else $error("array written while protect pin high");
   AST_LOW_HALF: assert property ( // RL3
      mem_bus.wr_en && swp_reg |-> mem_bus.wr_addr[HALF_BIT])
      else $error("protected lower half written");
   AST_DRIVE_ON_FALL: assert property ( // RL7
      $rose(sda_oe_reg) |-> $past(scl_fall))
      else $error("sda drive changed outside a falling clock");
   AST_NO_SWP_ACK: assert property ( // RL16
      s_dev_byte ##0 (shift_reg[CODE_MSB:CODE_LSB] == CODE_PROTECT &&
                      swp_reg) |=> !sda_oe_reg)
      else $error("protect code acknowledged after programming");
   AST_SEL_MATCH: assert property ( // RL10
      s_dev_byte ##0 (shift_reg[SEL_MSB:SEL_LSB] != strap_s)
      |=> !sda_oe_reg)
      else $error("acknowledged a foreign identity");
   AST_BUSY_QUIET: assert property ( // RL18
      state_reg == ST_PROG |=> !sda_oe_reg && !mem_bus.wr_en)
      else $error("bus activity during write cycle");
   AST_PAGE_WRAP: assert property ( // RL20
      mem_bus.wr_en |-> addr_reg == page_next(mem_bus.wr_addr))
      else $error("page pointer left its page");
   AST_PROG_START: assert property ( // RL13
      s_commit |=> state_reg == ST_PROG &&
                   prog_cnt_reg == PROG_CNT_W'(WR_CYCLES - 1))
      else $error("write cycle not started with full count");
   AST_ACK_WRITE: assert property ( // RL17
      byte_evt && state_reg == ST_WDATA |=> sda_oe_reg [*2])
      else $error("data byte not acknowledged");

endmodule
